/* File: verilog/isph_pkg.sv */
// isph_pkg: constants for the serial in-system programming host.
// assumes a 20 MHz core clock; long waits are top-level parameters.
package isph_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int CLK_NS = 1000000000 / CLK_HZ;
   localparam int RST_PULSE_NS = 1000;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int POWERUP_WAIT_US = 20000;
   localparam int FLASH_WAIT_US = 4500;
   localparam int EEPROM_WAIT_US = 3600;
   localparam int ERASE_WAIT_US = 9000;
   localparam int POWERUP_WAIT_CYC = POWERUP_WAIT_US * (CLK_HZ / 1000000);
   localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * (CLK_HZ / 1000000);
   localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * (CLK_HZ / 1000000);
   localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * (CLK_HZ / 1000000);
   localparam int SCK_HALF_CYC = 8;
   localparam int CNT_W = 32;

   // ----------------------------------------------------------------
   // instruction format
   // ----------------------------------------------------------------
   localparam int WORD_W = 32;
   localparam int BIT_W = 5;
   localparam logic [BIT_W-1:0] LAST_BIT = 5'h1f;
   localparam logic [7:0] OP_PROG_EN = 8'hac;
   localparam logic [7:0] PROG_EN_KEY = 8'h53;
   localparam logic [7:0] OP_ERASE_2ND = 8'h80;
   localparam logic [7:0] OP_POLL = 8'hf0;
   localparam logic [7:0] OP_LOAD_EXT = 8'h4d;
   localparam logic [7:0] OP_LOAD_HI = 8'h48;
   localparam logic [7:0] OP_LOAD_LO = 8'h40;
   localparam logic [7:0] OP_LOAD_EE_PAGE = 8'hc1;
   localparam logic [7:0] OP_READ_HI = 8'h28;
   localparam logic [7:0] OP_READ_LO = 8'h20;
   localparam logic [7:0] OP_READ_EE = 8'ha0;
   localparam logic [7:0] OP_READ_LOCK_FHI = 8'h58;
   localparam logic [7:0] OP_READ_FUSE = 8'h50;
   localparam logic [7:0] OP_READ_SIG = 8'h30;
   localparam logic [7:0] OP_READ_CAL = 8'h38;
   localparam logic [7:0] OP_WRITE_PAGE = 8'h4c;
   localparam logic [7:0] OP_WRITE_EE = 8'hc0;
   localparam logic [7:0] OP_WRITE_EE_PAGE = 8'hc2;
   localparam logic [7:0] SUB_LOCK = 8'he0;
   localparam logic [7:0] SUB_FUSE_LO = 8'ha0;
   localparam logic [7:0] SUB_FUSE_HI = 8'ha8;
   localparam logic [7:0] SUB_FUSE_EXT = 8'ha4;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int ECHO_LSB = 8;
   localparam int OPC_LSB = 24;
   localparam int POLL_BIT = 0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ISPH_WAIT_NONE = 2'h0,
      ISPH_WAIT_FLASH = 2'h1,
      ISPH_WAIT_EEPROM = 2'h2,
      ISPH_WAIT_ERASE = 2'h3
   } isph_wait_t;

   typedef enum logic [2:0] {
      ISPH_IDLE = 3'h0,
      ISPH_PULSE = 3'h1,
      ISPH_SETTLE = 3'h3,
      ISPH_ENABLE = 3'h2,
      ISPH_READY = 3'h6,
      ISPH_SHIFT = 3'h7,
      ISPH_WAIT = 3'h5,
      ISPH_POLL = 3'h4
   } isph_state_t;

   typedef enum logic [1:0] {
      ISPH_KIND_EN = 2'h0,
      ISPH_KIND_USER = 2'h1,
      ISPH_KIND_POLL = 2'h2
   } isph_kind_t;

endpackage : isph_pkg

/* File: verilog/isph_tick.sv */
// isph_tick: divider giving one-cycle enable pulses every half sck period.
// assumes core_clk domain; restarts its count while run is low.
`timescale 1ns/1ps
`default_nettype none
module isph_tick
   import isph_pkg::*;
#(
   parameter int HALF = SCK_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic run,
   output logic tick
);
   logic [15:0] cnt_reg;

   // ----------------------------------------------------------------
   // half-period counter
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn || !run || tick) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   assign tick = run && (cnt_reg == 16'(HALF - 1));

endmodule : isph_tick
`default_nettype wire

/* File: verilog/isph_host.sv */
// isph_host: serial in-system programming master for a reset-held target.
// assumes target clock at least 1/3 of the sck half-period rate; user side
// sends whole four-byte instructions and gets the four received bytes back.
//
// Function
// - sck low and high phases long enough
// - power-up holds reset, sck low; pulse reset
// - wait 20ms before programming enable
// - send all four bytes; retry on bad echo
// - page loads low byte before high byte
// - extended address kept; load before crossing
// - timed waits after flash, eeprom, erase writes
// - poll f0 until busy bit clears
// - load opcodes 4d, 48, 40, c1
// - no access before flash write finishes
// - releasing reset ends the session
// - leave unused fuse, lock bits at one
// - programming only with reset low, enabled
`timescale 1ns/1ps
`default_nettype none
module isph_host
   import isph_pkg::*;
#(
   parameter int POWERUP_WAIT = POWERUP_WAIT_CYC,
   parameter int FLASH_WAIT = FLASH_WAIT_CYC,
   parameter int EEPROM_WAIT = EEPROM_WAIT_CYC,
   parameter int ERASE_WAIT = ERASE_WAIT_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic sess_start,
   input wire logic sess_end,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [WORD_W-1:0] cmd_word,
   input wire logic [1:0] cmd_wait,
   input wire logic cmd_poll,
   output logic rsp_valid,
   output logic [WORD_W-1:0] rsp_word,
   output logic sess_active,
   output logic echo_fail,
   output logic tgt_reset,
   output logic tgt_sck,
   output logic prog_serial_in,
   input wire logic prog_serial_out
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   isph_state_t state_reg;
   isph_kind_t kind_reg;
   isph_wait_t wait_reg;
   logic poll_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [WORD_W-1:0] tx_reg;
   logic [WORD_W-1:0] rx_reg;
   logic [BIT_W-1:0] bit_reg;
   logic sdo_meta_reg;
   logic sdo_sync_reg;
   logic tick;
   logic shift_done;
   logic cnt_zero;
   logic echo_ok;
   logic [WORD_W-1:0] rx_word;
   logic poll_busy;

   // ----------------------------------------------------------------
   // data-out synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         sdo_meta_reg <= 1'b0;
         sdo_sync_reg <= 1'b0;
      end else begin
         sdo_meta_reg <= prog_serial_out;
         sdo_sync_reg <= sdo_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // sck phase divider
   // ----------------------------------------------------------------
   isph_tick #(
      .HALF(SCK_HALF_CYC)
   ) u_tick (
      .core_clk(core_clk),
      .resetn(resetn),
      .run(state_reg == ISPH_SHIFT),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // status and handshake
   // ----------------------------------------------------------------
   assign rx_word = {rx_reg[WORD_W-2:0], sdo_sync_reg};
   assign poll_busy = rx_word[POLL_BIT];
   assign shift_done = tick && tgt_sck && (bit_reg == LAST_BIT);
   assign cnt_zero = (cnt_reg == '0);
   assign echo_ok = (rx_reg[ECHO_LSB +: 8] == PROG_EN_KEY);
   assign cmd_ready = (state_reg == ISPH_READY) && !sess_end;
   assign sess_active = (state_reg == ISPH_READY) || (state_reg == ISPH_SHIFT && 
      kind_reg != ISPH_KIND_EN) || (state_reg == ISPH_WAIT) || (state_reg == ISPH_POLL);

   // ----------------------------------------------------------------
   // session and command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_reg <= ISPH_IDLE;
         kind_reg <= ISPH_KIND_EN;
         wait_reg <= ISPH_WAIT_NONE;
         poll_reg <= 1'b0;
         cnt_reg <= '0;
         tgt_reset <= 1'b0;
      end else begin
         case (state_reg)
            ISPH_IDLE: begin
               // pin level kept: low from power-up, high after a session
               if (sess_start) begin
                  tgt_reset <= 1'b1;
                  cnt_reg <= CNT_W'(RST_PULSE_CYC);
                  state_reg <= ISPH_PULSE;
               end
            end
            ISPH_PULSE: begin
               if (cnt_zero) begin
                  tgt_reset <= 1'b0;
                  cnt_reg <= CNT_W'(POWERUP_WAIT);
                  state_reg <= ISPH_SETTLE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ISPH_SETTLE: begin
               if (cnt_zero) begin
                  kind_reg <= ISPH_KIND_EN;
                  state_reg <= ISPH_SHIFT;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ISPH_ENABLE: begin
               // key byte comes back in the third received byte
               if (echo_ok) begin
                  state_reg <= ISPH_READY;
               end else begin
                  tgt_reset <= 1'b1;
                  cnt_reg <= CNT_W'(RST_PULSE_CYC);
                  state_reg <= ISPH_PULSE;
               end
            end
            ISPH_READY: begin
               if (sess_end) begin
                  tgt_reset <= 1'b1;
                  state_reg <= ISPH_IDLE;
               end else if (cmd_valid) begin
                  kind_reg <= ISPH_KIND_USER;
                  wait_reg <= isph_wait_t'(cmd_wait);
                  poll_reg <= cmd_poll;
                  state_reg <= ISPH_SHIFT;
               end
            end
            ISPH_SHIFT: begin
               if (shift_done) begin
                  case (kind_reg)
                     ISPH_KIND_EN: state_reg <= ISPH_ENABLE;
                     ISPH_KIND_POLL: begin
                        if (poll_busy) begin
                           state_reg <= ISPH_POLL;
                        end else begin
                           state_reg <= ISPH_READY;
                        end
                     end
                     default: begin
                        if (wait_reg == ISPH_WAIT_NONE) begin
                           state_reg <= ISPH_READY;
                        end else if (poll_reg) begin
                           state_reg <= ISPH_POLL;
                        end else begin
                           state_reg <= ISPH_WAIT;
                           case (wait_reg)
                              ISPH_WAIT_FLASH: cnt_reg <= CNT_W'(FLASH_WAIT);
                              ISPH_WAIT_EEPROM: cnt_reg <= CNT_W'(EEPROM_WAIT);
                              default: cnt_reg <= CNT_W'(ERASE_WAIT);
                           endcase
                        end
                     end
                  endcase
               end
            end
            ISPH_WAIT: begin
               if (cnt_zero) begin
                  state_reg <= ISPH_READY;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ISPH_POLL: begin
               // poll word is loaded by the transmit shifter this cycle
               kind_reg <= ISPH_KIND_POLL;
               state_reg <= ISPH_SHIFT;
            end
            default: state_reg <= ISPH_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sck phases and bit count
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tgt_sck <= 1'b0;
         bit_reg <= '0;
      end else if (state_reg != ISPH_SHIFT) begin
         tgt_sck <= 1'b0;
         bit_reg <= '0;
      end else if (tick) begin
         if (!tgt_sck) begin
            tgt_sck <= 1'b1;
         end else begin
            tgt_sck <= 1'b0;
            bit_reg <= bit_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // transmit shifter: data set while sck low
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tx_reg <= '0;
         prog_serial_in <= 1'b0;
      end else if (state_reg != ISPH_SHIFT) begin
         if (state_reg == ISPH_SETTLE) begin
            tx_reg <= {OP_PROG_EN, PROG_EN_KEY, BYTE_ZERO, BYTE_ZERO};
            prog_serial_in <= OP_PROG_EN[7];
         end else if (state_reg == ISPH_POLL) begin
            tx_reg <= {OP_POLL, BYTE_ZERO, BYTE_ZERO, BYTE_ZERO};
            prog_serial_in <= OP_POLL[7];
         end else if (state_reg == ISPH_READY && cmd_valid && !sess_end) begin
            tx_reg <= cmd_word;
            prog_serial_in <= cmd_word[WORD_W-1];
         end
      end else if (tick && tgt_sck) begin
         tx_reg <= {tx_reg[WORD_W-2:0], 1'b0};
         prog_serial_in <= tx_reg[WORD_W-2];
      end
   end

   // ----------------------------------------------------------------
   // receive shifter: synchronised data taken at end of high phase
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rx_reg <= '0;
      end else if (state_reg == ISPH_SHIFT && tick && tgt_sck) begin
         rx_reg <= rx_word;
      end
   end

   // ----------------------------------------------------------------
   // answer to the user side
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
         rsp_word <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (shift_done && kind_reg == ISPH_KIND_USER) begin
            rsp_valid <= 1'b1;
            rsp_word <= rx_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // echo failure pulse
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         echo_fail <= 1'b0;
      end else begin
         echo_fail <= (state_reg == ISPH_ENABLE) && !echo_ok;
      end
   end

endmodule : isph_host
`default_nettype wire

/* File: tb/isph_host_checker.sv */
// isph_host_checker: concurrent checks on the programming host ports.
// assumes binding to isph_host; long waits come from its parameters.
`timescale 1ns/1ps
`default_nettype none
module isph_host_checker
   import isph_pkg::*;
#(
   parameter int POWERUP_WAIT = POWERUP_WAIT_CYC,
   parameter int FLASH_WAIT = FLASH_WAIT_CYC,
   parameter int EEPROM_WAIT = EEPROM_WAIT_CYC,
   parameter int ERASE_WAIT = ERASE_WAIT_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic sess_start,
   input wire logic sess_end,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [WORD_W-1:0] cmd_word,
   input wire logic [1:0] cmd_wait,
   input wire logic cmd_poll,
   input wire logic rsp_valid,
   input wire logic [WORD_W-1:0] rsp_word,
   input wire logic sess_active,
   input wire logic echo_fail,
   input wire logic tgt_reset,
   input wire logic tgt_sck,
   input wire logic prog_serial_in,
   input wire logic prog_serial_out
);
   // ----------------------------------------------------------------
   // helper counters
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   int since_rst;
   int gap;
   int need;
   always_ff @(posedge core_clk) begin
      if (!resetn || tgt_reset) since_rst <= 0;
      else if (since_rst < POWERUP_WAIT + 8) since_rst <= since_rst + 1;
   end
   always_ff @(posedge core_clk) begin
      if (!resetn || rsp_valid) gap <= 0;
      else if (gap < 1000000) gap <= gap + 1;
   end
   always_ff @(posedge core_clk) begin
      if (!resetn) need <= 0;
      else if (cmd_valid && cmd_ready) need <= cmd_poll ? 0 : (cmd_wait == 2'h1) ? FLASH_WAIT :
         (cmd_wait == 2'h2) ? EEPROM_WAIT : (cmd_wait == 2'h3) ? ERASE_WAIT : 0;
   end
   chk_sck_low_time: assert property ($fell(tgt_sck) |-> !tgt_sck [*8])
      else $error("sck low phase too short");
   chk_sck_high_time: assert property ($rose(tgt_sck) |-> tgt_sck [*8])
      else $error("sck high phase too short");
   chk_data_at_rise: assert property ($rose(tgt_sck) |->
      $stable(prog_serial_in) ##1 $stable(prog_serial_in))
      else $error("data moved at sck rise");
   chk_reset_pulse: assert property ($rose(tgt_reset) && !$past(sess_active) |->
      tgt_reset [*8] ##13 tgt_reset ##1 !tgt_reset)
      else $error("reset pulse length wrong");
   chk_powerup_wait: assert property ($rose(tgt_sck) |-> since_rst >= POWERUP_WAIT)
      else $error("shift began before power-up wait");
   chk_whole_word: assert property (cmd_valid && cmd_ready |->
      ##256 1'b1 ##[257:258] rsp_valid)
      else $error("instruction not shifted in 32 bits");
   chk_write_wait: assert property ($rose(cmd_ready) |-> gap >= need)
      else $error("next instruction before write wait");
   chk_ready_prog: assert property (cmd_ready |-> !tgt_reset && sess_active)
      else $error("ready outside programming mode");
   chk_echo_retry: assert property (echo_fail |-> ##[1:3] tgt_reset)
      else $error("no reset pulse after bad echo");
endmodule : isph_host_checker

bind isph_host isph_host_checker #(.POWERUP_WAIT(POWERUP_WAIT), .FLASH_WAIT(FLASH_WAIT),
   .EEPROM_WAIT(EEPROM_WAIT), .ERASE_WAIT(ERASE_WAIT)) i_chk (.core_clk(core_clk),
   .resetn(resetn), .sess_start(sess_start), .sess_end(sess_end), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_word(cmd_word), .cmd_wait(cmd_wait), .cmd_poll(cmd_poll),
   .rsp_valid(rsp_valid), .rsp_word(rsp_word), .sess_active(sess_active),
   .echo_fail(echo_fail), .tgt_reset(tgt_reset), .tgt_sck(tgt_sck),
   .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out));
`default_nettype wire

/* File: tb/isph_dev_model.sv */
// isph_dev_model: behavioural target of the serial programming port.
// assumes sck far slower than core_clk, which oversamples it.
`timescale 1ns/1ps
`default_nettype none
module isph_dev_model
   import isph_pkg::*;
#(
   parameter logic [7:0] SIG = 8'h5e, // arbitrary value
   parameter int BUSY = 1000
) (
   input wire logic core_clk,
   input wire logic tgt_reset,
   input wire logic tgt_sck,
   input wire logic prog_serial_in,
   input wire logic bad_echo,
   output logic prog_serial_out,
   output logic enabled,
   output logic pending
);
   // ----------------------------------------------------------------
   // shift and execute
   // ----------------------------------------------------------------
   logic sck_q = 1'b0;
   logic [31:0] rx = '0;
   logic [5:0] n = '0;
   logic [7:0] tx = '0;
   logic [7:0] ext;
   int busy = 0;
   logic [15:0] pb [0:7];
   logic [15:0] fl [0:7];
   logic [7:0] ee [0:7];
   logic [7:0] fz [0:3];
   wire logic [31:0] w = {rx[30:0], prog_serial_in};
   // line shows inverse while tgt_reset is high
   assign prog_serial_out = tgt_reset ? ~tx[7] : tx[7];
   assign pending = (busy != 0);
   function automatic logic [7:0] ans(input logic [23:0] b);
      case (b[23:16])
         8'hf0: ans = {7'h0, busy != 0};
         8'h20: ans = fl[b[2:0]][7:0];
         8'h28: ans = fl[b[2:0]][15:8];
         8'ha0: ans = ee[b[2:0]];
         8'h58: ans = b[11] ? fz[2] : fz[0];
         8'h50: ans = b[11] ? fz[3] : fz[1];
         8'h30: ans = SIG;
         default: ans = b[7:0];
      endcase
   endfunction : ans
   always @(posedge core_clk) begin
      sck_q <= tgt_sck;
      if (busy > 0) busy <= busy - 1;
      if (tgt_reset) begin
         n <= '0;
         enabled <= 1'b0;
      end else if (tgt_sck && !sck_q) begin
         rx <= w;
         n <= (n == 6'd31) ? 6'd0 : n + 6'd1;
         if (n == 6'd31 && w == 32'hac530000) enabled <= 1'b1;
         else if (n == 6'd31 && enabled) begin
            case (w[31:24])
               8'h40: pb[w[10:8]][7:0] <= w[7:0];
               8'h48: pb[w[10:8]][15:8] <= w[7:0];
               8'h4d: ext <= w[15:8];
               8'h4c: begin
                  fl <= pb;
                  busy <= BUSY;
               end
               8'hc0: ee[w[10:8]] <= w[7:0];
               8'hac: case (w[23:16])
                  8'h80: for (int i = 0; i < 8; i++) begin
                     fl[i] <= 16'hffff;
                     ee[i] <= 8'hff;
                  end
                  8'he0: fz[0] <= w[7:0];
                  8'ha0: fz[1] <= w[7:0];
                  8'ha8: fz[2] <= w[7:0];
                  8'ha4: fz[3] <= w[7:0];
                  default: ;
               endcase
               default: ;
            endcase
         end
      end else if (!tgt_sck && sck_q && n != 6'd0) begin
         if (n[2:0] == 3'h0) tx <= (n == 6'd24) ? ans(rx[23:0]) :
            (n == 6'd16 && bad_echo) ? ~rx[7:0] : rx[7:0];
         else tx <= {tx[6:0], 1'b0};
      end
   end
endmodule : isph_dev_model
`default_nettype wire

/* File: tb/isph_host_tb.sv */
// isph_host_tb: self-checking bench of the programming host.
// assumes isph_dev_model as target and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module isph_host_tb;
   import isph_pkg::*;
   // ----------------------------------------------------------------
   // bench
   // ----------------------------------------------------------------
   localparam logic [7:0] SIG_CODE = 8'h5e; // arbitrary value
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic sess_start = 1'b0;
   logic sess_end = 1'b0;
   logic cmd_valid = 1'b0;
   logic [31:0] cmd_word = '0;
   logic [1:0] cmd_wait = 2'h0;
   logic cmd_poll = 1'b0;
   logic bad_echo = 1'b1;
   logic [31:0] r;
   wire logic cmd_ready, rsp_valid, sess_active, echo_fail, tgt_reset, tgt_sck;
   wire logic prog_serial_in, prog_serial_out, dev_en, dev_busy;
   wire logic [31:0] rsp_word;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   int fails = 0;
   isph_host #(.POWERUP_WAIT(200), .FLASH_WAIT(50), .EEPROM_WAIT(40), .ERASE_WAIT(100)) i_dut (
      .core_clk(core_clk), .resetn(resetn), .sess_start(sess_start), .sess_end(sess_end),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word), .cmd_wait(cmd_wait),
      .cmd_poll(cmd_poll), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
      .sess_active(sess_active), .echo_fail(echo_fail), .tgt_reset(tgt_reset),
      .tgt_sck(tgt_sck), .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out));
   isph_dev_model #(.SIG(SIG_CODE), .BUSY(1000)) i_dev (.core_clk(core_clk),
      .tgt_reset(tgt_reset), .tgt_sck(tgt_sck), .prog_serial_in(prog_serial_in),
      .bad_echo(bad_echo), .prog_serial_out(prog_serial_out), .enabled(dev_en),
      .pending(dev_busy));
   initial forever #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (echo_fail === 1'b1) begin
         fails <= fails + 1;
         bad_echo <= 1'b0;
      end
      if (cyc == 40000) begin
         $display("BAD t=%0t cyc=%h limit=%h", $time, cyc, 40000);
         n_fail = n_fail + 1;
         stop_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cmd(input logic [31:0] w, input logic [1:0] wt, input logic pl);
      int k;
      k = 0;
      cmd_word <= w;
      cmd_wait <= wt;
      cmd_poll <= pl;
      cmd_valid <= 1'b1;
      do begin @(posedge core_clk); k++; end while (cmd_ready !== 1'b1 && k < 30000);
      chk({7'h0, cmd_ready}, 8'h01);
      cmd_valid <= 1'b0;
      k = 0;
      do begin @(posedge core_clk); k++; end while (rsp_valid !== 1'b1 && k < 600);
      chk({7'h0, rsp_valid}, 8'h01);
      r = rsp_word;
      chk(r[15:8], w[23:16]);
   endtask : cmd
   task automatic t_session();
      int k;
      k = 0;
      @(posedge core_clk) sess_start <= 1'b1;
      @(posedge core_clk) sess_start <= 1'b0;
      while (cmd_ready !== 1'b1 && k < 5000) begin @(posedge core_clk); k++; end
      chk({7'h0, cmd_ready}, 8'h01);
      chk(fails[7:0], 8'h01);
      chk({7'h0, tgt_reset}, 8'h00);
      $display("session start done");
   endtask : t_session
   task automatic t_flash();
      cmd(32'h4d000000, 2'h0, 1'b0);
      cmd(32'h4000025a, 2'h0, 1'b0);
      cmd(32'h480002c3, 2'h0, 1'b0);
      cmd(32'h4c000000, 2'h1, 1'b1);
      while (cmd_ready !== 1'b1) @(posedge core_clk);
      chk({7'h0, dev_busy}, 8'h00);
      cmd(32'h20000200, 2'h0, 1'b0);
      chk(r[7:0], 8'h5a);
      cmd(32'h28000200, 2'h0, 1'b0);
      chk(r[7:0], 8'hc3);
      $display("flash page done");
   endtask : t_flash
   task automatic t_eeprom();
      cmd(32'hc0000377, 2'h2, 1'b0);
      cmd(32'hc0000318, 2'h2, 1'b0);
      cmd(32'ha0000300, 2'h0, 1'b0);
      chk(r[7:0], 8'h18);
      $display("eeprom done");
   endtask : t_eeprom
   task automatic t_fuse();
      logic [7:0] sub [4] = '{8'he0, 8'ha0, 8'ha8, 8'ha4};
      logic [15:0] rd [4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
      for (int i = 0; i < 4; i++) begin
         cmd({8'hac, sub[i], 8'h00, 8'hf0 | 8'(i)}, 2'h1, 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         cmd({rd[i], 16'h0000}, 2'h0, 1'b0);
         chk(r[7:0], 8'hf0 | 8'(i));
      end
      cmd(32'h30000000, 2'h0, 1'b0);
      chk(r[7:0], SIG_CODE);
      $display("fuse and lock done");
   endtask : t_fuse
   task automatic t_erase();
      cmd(32'hac800000, 2'h3, 1'b0);
      cmd(32'h20000200, 2'h0, 1'b0);
      chk(r[7:0], 8'hff);
      cmd(32'ha0000300, 2'h0, 1'b0);
      chk(r[7:0], 8'hff);
      $display("chip erase done");
   endtask : t_erase
   task automatic t_end();
      int k;
      k = 0;
      sess_end <= 1'b1;
      while (tgt_reset !== 1'b1 && k < 2000) begin @(posedge core_clk); k++; end
      sess_end <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk({7'h0, tgt_reset}, 8'h01);
      chk({7'h0, sess_active}, 8'h00);
      chk({7'h0, dev_en}, 8'h00);
      $display("session end done");
   endtask : t_end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      t_session();
      t_flash();
      t_eeprom();
      t_fuse();
      t_erase();
      t_end();
      stop_test();
   end
endmodule : isph_host_tb
`default_nettype wire
